// >>> bench/testbench.sv
// Purpose: self-checking bench for the ACL indirect access block over AXI4-Lite
// Assumes: byte address = 4 * index, bus answers within the bounded waits below
// Notes: a table write then a partial table read on another staging pattern
`include "acl_regs.svh"
module testbench import acl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************************************
  // signals and design instance
  // ****************************************************************
  localparam logic [5:0] ctrl_idx = `ACL_TRANSFER_CONTROL_IDX;
  localparam logic [5:0] selh_idx = `ACL_BYTE_SELECT_HIGH_IDX;
  localparam logic [5:0] sell_idx = `ACL_BYTE_SELECT_LOW_GO_IDX;
  logic mclk, rst, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, match_on_equal, compare_source, xfer_busy;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rule_map_mode;
  logic [2:0] remark_priority, fwd_port_enable;
  logic [15:0] ruleset;
  rule_mode_e rule_mode;
  int bad_count, num_checks;

  acl_table_indirect_access acl_table_indirect_access_i (.mclk(mclk), .rst(rst), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .rule_mode(rule_mode),
    .match_on_equal(match_on_equal), .compare_source(compare_source), .rule_map_mode(rule_map_mode),
    .remark_priority(remark_priority), .fwd_port_enable(fwd_port_enable), .ruleset(ruleset),
    .xfer_busy(xfer_busy));

  always #4 mclk = ~mclk;

  // ****************************************************************
  // checking and bus tasks
  // ****************************************************************
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
    begin
      $display("Simulation passed");
    end
    else
    begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic hang();
    bad_count++;
    $display("unexpected at %0t: wait ran out", $time);
    report_and_stop();
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // handshakes are sampled at the falling edge, which sees what the next rising edge takes
  task automatic wr(input logic [5:0] idx, input byte_t d, input logic [1:0] er = 2'b00);
    int n;
    logic a, w, b;
    logic [1:0] r;
    n = 0;
    b = 1'b0;
    @(posedge mclk);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!b && n < 64)
    begin
      @(negedge mclk);
      a = awready;
      w = wready;
      b = bvalid;
      r = bresp;
      @(posedge mclk);
      if (a) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
      n++;
    end
    bready <= 1'b0;
    if (!b) hang();
    else chk(32'(r), 32'(er));
  endtask

  task automatic rd(input logic [5:0] idx, output logic [31:0] q, output logic [1:0] rr);
    int n;
    logic a, v;
    n = 0;
    v = 1'b0;
    @(posedge mclk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!v && n < 64)
    begin
      @(negedge mclk);
      a = arready;
      v = rvalid;
      q = rdata;
      rr = rresp;
      @(posedge mclk);
      if (a) arvalid <= 1'b0;
      n++;
    end
    rready <= 1'b0;
    if (!v) hang();
  endtask

  task automatic rc(input logic [5:0] idx, input logic [31:0] e, input logic [1:0] er = 2'b00);
    logic [31:0] q;
    logic [1:0] rr;
    rd(idx, q, rr);
    chk(q, e);
    chk(32'(rr), 32'(er));
  endtask

  // polling keeps the host from trusting staging bytes before the transfer ends
  task automatic wait_done(input int bitn);
    int n;
    logic [31:0] q;
    logic [1:0] rr;
    n = 0;
    q = '0;
    while (q[bitn] !== 1'b1 && n < 40)
    begin
      rd(ctrl_idx, q, rr);
      n++;
    end
    if (q[bitn] !== 1'b1) hang();
  endtask

  // staging pattern: distinct per lane, upper nibble of lane 0 is not stored
  function automatic logic [31:0] pat(input int k);
    logic [7:0] v;
    v = {4'(k) ^ 4'ha, 4'hf - 4'(k)};
    if (k == 0) v = v & 8'h0f;
    return {24'h000000, v};
  endfunction

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial
  begin
    logic [1:0] mm;
    mclk = 1'b0;
    rst = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h00000000;
    wstrb = 4'hf;
    bad_count = 0;
    num_checks = 0;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    rc(ctrl_idx, 32'h60);
    rc(selh_idx, 32'h0);
    rc(sell_idx, 32'h0);
    for (int k = 0; k < 16; k++) rc(6'(k), 32'h0);
    for (int m = 0; m < 4; m++)
    begin
      mm = 2'(m);
      wr(`ACL_RULE_MODE_IDX, {2'b00, mm, 2'b00, mm[0], ~mm[0]});
      @(negedge mclk);
      chk(32'(rule_mode), 32'(mm));
      chk(32'(compare_source), 32'(mm[0]));
      chk(32'(match_on_equal), {31'h0, ~mm[0]});
    end
    wr(`ACL_REMARK_HIGH_IDX, 8'h02);
    wr(`ACL_REMARK_LSB_MAP_MODE_IDX, 8'hc0);
    wr(`ACL_FORWARD_PORT_MAP_IDX, 8'h05);
    wr(`ACL_RULESET_HIGH_IDX, 8'ha5);
    wr(`ACL_RULESET_LOW_IDX, 8'h3c);
    @(negedge mclk);
    chk(32'(remark_priority), 32'h5);
    chk(32'(rule_map_mode), 32'h2);
    chk(32'(fwd_port_enable), 32'h5);
    chk(32'(ruleset), 32'ha53c);
    for (int k = 0; k < 16; k++) wr(6'(k), 8'(pat(k)));
    for (int k = 0; k < 16; k++) rc(6'(k), pat(k));
    // a beat without the low strobe stores nothing but is still answered OKAY
    wstrb <= 4'he;
    wr(6'h05, 8'h00);
    wstrb <= 4'hf;
    rc(6'h05, pat(5));
    // table write of every lane into entry 3
    wr(ctrl_idx, 8'h13);
    rc(ctrl_idx, 32'h73);
    wr(selh_idx, 8'hff);
    wr(sell_idx, 8'hff);
    @(negedge mclk);
    chk(32'(xfer_busy), 32'h1);
    rc(ctrl_idx, 32'h33);
    wr(6'h02, 8'h00);
    wait_done(6);
    rc(ctrl_idx, 32'h73);
    rc(6'h02, pat(2));
    // entry 4 gets zeros so a wrong index shows up on the read back
    for (int k = 0; k < 16; k++) wr(6'(k), 8'h00);
    wr(ctrl_idx, 8'h14);
    wr(selh_idx, 8'hff);
    wr(sell_idx, 8'hff);
    wait_done(6);
    // partial table read of entry 3: lanes 0 and 7 from the high enables, 8 and 15 from the low
    wr(ctrl_idx, 8'h03);
    wr(selh_idx, 8'h81);
    wr(sell_idx, 8'h81);
    rc(ctrl_idx, 32'h43);
    wait_done(5);
    rc(ctrl_idx, 32'h63);
    rc(selh_idx, 32'h81);
    for (int k = 0; k < 16; k++) rc(6'(k), (k == 0 || k == 7 || k == 8 || k == 15) ? pat(k) : 32'h0);
    // unmapped index
    wr(6'h13, 8'h5a, 2'b10);
    rc(6'h13, 32'h0, 2'b10);
    report_and_stop();
  end
endmodule

// >>> rtl/acl_entry_store.sv
// Purpose: table of ACL entries, one byte lane written per cycle
// Assumes: single clock, writer and reader never touch the same lane twice at once
// Notes: asynchronous read so the mover finishes one lane per cycle; no reset on contents
module acl_entry_store import acl_pkg::*;
#(
  parameter int ENTRIES = 16,
  parameter int LANES = 16
)
(
  input wire logic mclk,
  input wire logic we,
  input wire logic [$clog2(ENTRIES)-1:0] entry,
  input wire logic [$clog2(LANES)-1:0] lane,
  input wire byte_t wdata,
  output byte_t rdata
);

  byte_t mem [0:ENTRIES-1][0:LANES-1];

  always_ff @(posedge mclk)
  begin
    if (we)
    begin
      mem[entry][lane] <= wdata;
    end
  end

  assign rdata = mem[entry][lane];

endmodule

// >>> rtl/acl_pkg.sv
// Purpose: shared types of the ACL indirect access block
// Assumes: nothing beyond the header
// Notes: types only, numbers live in acl_regs.svh
package acl_pkg;

  typedef logic [7:0] byte_t;

  // rule comparison layer
  typedef enum logic [1:0] {mode_none, mode_l2_mac, mode_l3_ip, mode_l4_port} rule_mode_e;

  typedef enum logic {st_idle, st_move} xfer_state_e;

endpackage

// >>> rtl/acl_regs.svh
// Purpose: register indices, field positions and reset values of the ACL indirect access block
// Assumes: byte-wide registers, one per aligned 32-bit word, byte address = 4 * index
// Notes: definitions only
`ifndef ACL_REGS_SVH
`define ACL_REGS_SVH

// ****************************************************************
// register indices
// ****************************************************************
`define ACL_IDX_W 6
`define ACL_STAGE_FIRST_IDX 6'h00
`define ACL_RULE_MODE_IDX 6'h01
`define ACL_REMARK_HIGH_IDX 6'h0a
`define ACL_REMARK_LSB_MAP_MODE_IDX 6'h0b
`define ACL_SPARE_BYTE_IDX 6'h0c
`define ACL_FORWARD_PORT_MAP_IDX 6'h0d
`define ACL_RULESET_HIGH_IDX 6'h0e
`define ACL_RULESET_LOW_IDX 6'h0f
`define ACL_BYTE_SELECT_HIGH_IDX 6'h10
`define ACL_BYTE_SELECT_LOW_GO_IDX 6'h11
`define ACL_TRANSFER_CONTROL_IDX 6'h12
`define ACL_LAST_IDX 6'h12
`define ACL_AXI_ADDR_W 8

// ****************************************************************
// field positions
// ****************************************************************
`define ACL_CTRL_WR_DONE_BIT 6
`define ACL_CTRL_RD_DONE_BIT 5
`define ACL_CTRL_DIR_BIT 4
`define ACL_CTRL_INDEX_MSB 3
`define ACL_REMARK_LSB_BIT 7
`define ACL_MAP_MODE_MSB 6
`define ACL_MAP_MODE_LSB 5
`define ACL_RULE_MODE_MSB 5
`define ACL_RULE_MODE_LSB 4
`define ACL_SRC_DST_BIT 1
`define ACL_CMP_EQ_BIT 0
`define ACL_FWD_MAP_MSB 2

// ****************************************************************
// reset values, masks, counts
// ****************************************************************
`define ACL_STAGE_RST 8'h00
`define ACL_BYTE_SELECT_RST 8'h00
`define ACL_CTRL_RW_RST 5'h00
`define ACL_STATUS_RST 1'b1
`define ACL_STAGE0_WMASK 8'h0f
`define ACL_STAGE_WMASK 8'hff
`define ACL_STAGE_BYTES 16
`define ACL_LAST_LANE 4'hf
`define ACL_RESP_OKAY 2'b00
`define ACL_RESP_SLVERR 2'b10

`endif

// >>> rtl/acl_table_indirect_access.sv
// Purpose: per-port indirect access to the ACL table through byte-wide staging registers
// Assumes: AXI4-Lite register access, one core clock, synchronous active-high reset
// Notes: a transfer walks all sixteen lanes, one per cycle, moving only the selected ones
//
// Functional notes
// - remark priority lsb bit 7, map mode 6:5
// - forward map bits 2:0 enable ports 3:1
// - upper enables select staging bytes 7..0 reversed
// - lower enables select staging bytes F..8 reversed
// - low enable write starts; only selected bytes move
// - write status bit 6, resets one
// - read status bit 5, resets one
// - rule mode: none, l2 mac, l3 ip, l4
// - compare-equal and source/destination bit meanings
`include "acl_regs.svh"
module acl_table_indirect_access import acl_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [`ACL_AXI_ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [`ACL_AXI_ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output rule_mode_e rule_mode,
  output logic match_on_equal,
  output logic compare_source,
  output logic [1:0] rule_map_mode,
  output logic [2:0] remark_priority,
  output logic [2:0] fwd_port_enable,
  output logic [15:0] ruleset,
  output logic xfer_busy
);

  logic reg_wr_en;
  logic [`ACL_IDX_W-1:0] reg_wr_idx;
  byte_t reg_wr_data;
  logic [`ACL_IDX_W-1:0] reg_rd_idx;
  byte_t reg_rd_data;
  logic [`ACL_STAGE_BYTES-1:0][7:0] stage_ff;
  byte_t sel_high_ff;
  byte_t sel_low_ff;
  logic [15:0] lane_sel;
  logic [`ACL_CTRL_INDEX_MSB:0] entry_idx_ff;
  logic dir_write_ff;
  logic wr_done_ff;
  logic rd_done_ff;
  xfer_state_e state_ff;
  logic [3:0] lane_ff;
  logic bus_wr;
  logic start;
  logic mem_we;
  byte_t mem_rdata;
  default clocking cb_core @(posedge mclk);
  endclocking
  default disable iff (rst);

  // ****************************************************************
  // bus front end
  // ****************************************************************
  axil_reg_port axil_reg_port_i (
    .mclk(mclk),
    .rst(rst),
    .awaddr(awaddr),
    .awvalid(awvalid),
    .awready(awready),
    .wdata(wdata),
    .wstrb(wstrb),
    .wvalid(wvalid),
    .wready(wready),
    .bresp(bresp),
    .bvalid(bvalid),
    .bready(bready),
    .araddr(araddr),
    .arvalid(arvalid),
    .arready(arready),
    .rdata(rdata),
    .rresp(rresp),
    .rvalid(rvalid),
    .rready(rready),
    .reg_wr_en(reg_wr_en),
    .reg_wr_idx(reg_wr_idx),
    .reg_wr_data(reg_wr_data),
    .reg_rd_idx(reg_rd_idx),
    .reg_rd_data(reg_rd_data)
  );

  // staging and control are frozen while a transfer runs, so a stray write cannot tear an entry
  assign bus_wr = reg_wr_en && (state_ff == st_idle);
  assign start = bus_wr && (reg_wr_idx == `ACL_BYTE_SELECT_LOW_GO_IDX);

  // ****************************************************************
  // lane selection
  // ****************************************************************
  // lane k is chosen by enable bit 15-k of {high, low}
  assign lane_sel = {<<{sel_high_ff, sel_low_ff}};

  // ****************************************************************
  // transfer sequencer
  // ****************************************************************
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      state_ff <= st_idle;
      lane_ff <= 4'h0;
    end
    else
    begin
      case (state_ff)
        st_idle:
        begin
          lane_ff <= 4'h0;
          if (start)
          begin
            state_ff <= st_move;
          end
        end
        st_move:
        begin
          lane_ff <= lane_ff + 4'h1;
          if (lane_ff == `ACL_LAST_LANE)
          begin
            state_ff <= st_idle;
          end
        end
        default:
        begin
          state_ff <= st_idle;
        end
      endcase
    end
  end

  assign xfer_busy = (state_ff == st_move);
  // unselected lanes are skipped but still cost a cycle: fixed latency over speed
  assign mem_we = xfer_busy && dir_write_ff && lane_sel[lane_ff];

  acl_entry_store acl_entry_store_i (
    .mclk(mclk),
    .we(mem_we),
    .entry(entry_idx_ff),
    .lane(lane_ff),
    .wdata(stage_ff[lane_ff]),
    .rdata(mem_rdata)
  );

  // ****************************************************************
  // status bits
  // ****************************************************************
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      wr_done_ff <= `ACL_STATUS_RST;
      rd_done_ff <= `ACL_STATUS_RST;
    end
    else if (start)
    begin
      wr_done_ff <= wr_done_ff && !dir_write_ff;
      rd_done_ff <= rd_done_ff && dir_write_ff;
    end
    else if (xfer_busy && (lane_ff == `ACL_LAST_LANE))
    begin
      wr_done_ff <= wr_done_ff || dir_write_ff;
      rd_done_ff <= rd_done_ff || !dir_write_ff;
    end
  end

  // ****************************************************************
  // staging, byte select and control registers
  // ****************************************************************
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      for (int k = 0; k < `ACL_STAGE_BYTES; k++)
      begin
        stage_ff[k] <= `ACL_STAGE_RST;
      end
    end
    else
    begin
      for (int k = 0; k < `ACL_STAGE_BYTES; k++)
      begin
        if (xfer_busy && !dir_write_ff && (lane_ff == 4'(k)) && lane_sel[k])
        begin
          stage_ff[k] <= mem_rdata;
        end
        else if (bus_wr && (reg_wr_idx == 6'(k)))
        begin
          stage_ff[k] <= reg_wr_data & ((k == 0) ? `ACL_STAGE0_WMASK : `ACL_STAGE_WMASK);
        end
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      sel_high_ff <= `ACL_BYTE_SELECT_RST;
      sel_low_ff <= `ACL_BYTE_SELECT_RST;
    end
    else if (bus_wr)
    begin
      if (reg_wr_idx == `ACL_BYTE_SELECT_HIGH_IDX)
      begin
        sel_high_ff <= reg_wr_data;
      end
      if (reg_wr_idx == `ACL_BYTE_SELECT_LOW_GO_IDX)
      begin
        sel_low_ff <= reg_wr_data;
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      {dir_write_ff, entry_idx_ff} <= `ACL_CTRL_RW_RST;
    end
    else if (bus_wr && (reg_wr_idx == `ACL_TRANSFER_CONTROL_IDX))
    begin
      dir_write_ff <= reg_wr_data[`ACL_CTRL_DIR_BIT];
      entry_idx_ff <= reg_wr_data[`ACL_CTRL_INDEX_MSB:0];
    end
  end

  // ****************************************************************
  // read mux
  // ****************************************************************
  always_comb
  begin
    reg_rd_data = 8'h00;
    if (reg_rd_idx <= `ACL_RULESET_LOW_IDX)
    begin
      reg_rd_data = stage_ff[reg_rd_idx[3:0]];
    end
    else if (reg_rd_idx == `ACL_BYTE_SELECT_HIGH_IDX)
    begin
      reg_rd_data = sel_high_ff;
    end
    else if (reg_rd_idx == `ACL_BYTE_SELECT_LOW_GO_IDX)
    begin
      reg_rd_data = sel_low_ff;
    end
    else if (reg_rd_idx == `ACL_TRANSFER_CONTROL_IDX)
    begin
      reg_rd_data = {1'b0, wr_done_ff, rd_done_ff, dir_write_ff, entry_idx_ff};
    end
  end

  // ****************************************************************
  // decoded view of the staged rule
  // ****************************************************************
  assign rule_mode = rule_mode_e'(stage_ff[`ACL_RULE_MODE_IDX][`ACL_RULE_MODE_MSB:`ACL_RULE_MODE_LSB]);
  assign match_on_equal = stage_ff[`ACL_RULE_MODE_IDX][`ACL_CMP_EQ_BIT];
  assign compare_source = stage_ff[`ACL_RULE_MODE_IDX][`ACL_SRC_DST_BIT];
  assign rule_map_mode = stage_ff[`ACL_REMARK_LSB_MAP_MODE_IDX][`ACL_MAP_MODE_MSB:`ACL_MAP_MODE_LSB];
  assign remark_priority = {stage_ff[`ACL_REMARK_HIGH_IDX][1:0],
    stage_ff[`ACL_REMARK_LSB_MAP_MODE_IDX][`ACL_REMARK_LSB_BIT]};
  assign fwd_port_enable = stage_ff[`ACL_FORWARD_PORT_MAP_IDX][`ACL_FWD_MAP_MSB:0];
  assign ruleset = {stage_ff[`ACL_RULESET_HIGH_IDX], stage_ff[`ACL_RULESET_LOW_IDX]};

  // ****************************************************************
  // checks
  // ****************************************************************
  property p_wr_status_cycle;
    (start && dir_write_ff) |-> ##1 !wr_done_ff ##15 !wr_done_ff ##1 wr_done_ff;
  endproperty
  a_wr_status_cycle: assert property (p_wr_status_cycle) else $error("write status timing wrong");
  property p_rd_status_cycle;
    (start && !dir_write_ff) |-> ##1 !rd_done_ff ##15 !rd_done_ff ##1 rd_done_ff;
  endproperty
  a_rd_status_cycle: assert property (p_rd_status_cycle) else $error("read status timing wrong");
  property p_other_status_kept;
    (start && dir_write_ff) |=> $stable(rd_done_ff);
  endproperty
  a_other_status_kept: assert property (p_other_status_kept) else $error("read status moved on write");
  property p_unselected_kept;
    (xfer_busy && !dir_write_ff && !lane_sel[lane_ff]) |=> $stable(stage_ff);
  endproperty
  a_unselected_kept: assert property (p_unselected_kept) else $error("unselected byte changed");
  property p_selected_loaded;
    (xfer_busy && !dir_write_ff && lane_sel[lane_ff]) |=> stage_ff[$past(lane_ff)] == $past(mem_rdata);
  endproperty
  a_selected_loaded: assert property (p_selected_loaded) else $error("selected byte not loaded");
  property p_lane_order;
    (bus_wr && (reg_wr_idx == `ACL_BYTE_SELECT_LOW_GO_IDX)) |=>
      (lane_sel[15] == $past(reg_wr_data[0])) && (lane_sel[8] == $past(reg_wr_data[7]));
  endproperty
  a_lane_order: assert property (p_lane_order) else $error("low enable mapping wrong");
  property p_lane_order_high;
    (bus_wr && (reg_wr_idx == `ACL_BYTE_SELECT_HIGH_IDX)) |=>
      (lane_sel[7] == $past(reg_wr_data[0])) && (lane_sel[0] == $past(reg_wr_data[7]));
  endproperty
  a_lane_order_high: assert property (p_lane_order_high) else $error("high enable mapping wrong");
  property p_write_dir_only;
    mem_we |-> dir_write_ff && xfer_busy && $stable(entry_idx_ff);
  endproperty
  a_write_dir_only: assert property (p_write_dir_only) else $error("table written outside a write");
  property p_map_mode_field;
    (bus_wr && (reg_wr_idx == `ACL_REMARK_LSB_MAP_MODE_IDX)) |=>
      (rule_map_mode == $past(reg_wr_data[6:5])) && (remark_priority[0] == $past(reg_wr_data[7]));
  endproperty
  a_map_mode_field: assert property (p_map_mode_field) else $error("map mode or remark lsb wrong");
  property p_fwd_map;
    (bus_wr && (reg_wr_idx == `ACL_FORWARD_PORT_MAP_IDX)) |=> fwd_port_enable == $past(reg_wr_data[2:0]);
  endproperty
  a_fwd_map: assert property (p_fwd_map) else $error("forward map wrong");
  property p_rule_fields;
    (bus_wr && (reg_wr_idx == `ACL_RULE_MODE_IDX)) |=>
      (rule_mode == rule_mode_e'($past(reg_wr_data[5:4]))) && (match_on_equal == $past(reg_wr_data[0]))
      && (compare_source == $past(reg_wr_data[1]));
  endproperty
  a_rule_fields: assert property (p_rule_fields) else $error("rule field decode wrong");

endmodule

// >>> rtl/axil_reg_port.sv
// Purpose: AXI4-Lite slave front end turning bus beats into byte register strobes
// Assumes: one write and one read at a time; data in the low byte lane
// Notes: unmapped index answers SLVERR and reads zero
`include "acl_regs.svh"
module axil_reg_port import acl_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [`ACL_AXI_ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [`ACL_AXI_ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic reg_wr_en,
  output logic [`ACL_IDX_W-1:0] reg_wr_idx,
  output byte_t reg_wr_data,
  output logic [`ACL_IDX_W-1:0] reg_rd_idx,
  input wire byte_t reg_rd_data
);

  logic aw_held_ff;
  logic w_held_ff;
  logic [`ACL_AXI_ADDR_W-1:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic wstrb0_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic rvalid_ff;
  logic [1:0] rresp_ff;
  logic [31:0] rdata_ff;
  logic commit;
  logic wr_mapped;
  logic rd_mapped;

  // ****************************************************************
  // write channels: address and data in either order
  // ****************************************************************
  assign awready = !aw_held_ff && !bvalid_ff;
  assign wready = !w_held_ff && !bvalid_ff;
  assign commit = aw_held_ff && w_held_ff && !bvalid_ff;
  assign reg_wr_idx = awaddr_ff[`ACL_AXI_ADDR_W-1:2];
  assign wr_mapped = (reg_wr_idx <= `ACL_LAST_IDX);
  assign reg_wr_en = commit && wr_mapped && wstrb0_ff;
  assign reg_wr_data = wdata_ff[7:0];

  always_ff @(posedge mclk)
  begin
    if (rst || commit)
    begin
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
    end
    else
    begin
      if (awvalid && awready)
      begin
        aw_held_ff <= 1'b1;
      end
      if (wvalid && wready)
      begin
        w_held_ff <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      awaddr_ff <= '0;
      wdata_ff <= 32'h0;
      wstrb0_ff <= 1'b0;
    end
    else
    begin
      if (awvalid && awready)
      begin
        awaddr_ff <= awaddr;
      end
      if (wvalid && wready)
      begin
        wdata_ff <= wdata;
        wstrb0_ff <= wstrb[0];
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      bvalid_ff <= 1'b0;
      bresp_ff <= `ACL_RESP_OKAY;
    end
    else if (commit)
    begin
      bvalid_ff <= 1'b1;
      bresp_ff <= wr_mapped ? `ACL_RESP_OKAY : `ACL_RESP_SLVERR;
    end
    else if (bready)
    begin
      bvalid_ff <= 1'b0;
    end
  end

  assign bvalid = bvalid_ff;
  assign bresp = bresp_ff;

  // ****************************************************************
  // read channels: data captured at the address handshake
  // ****************************************************************
  assign arready = !rvalid_ff;
  assign reg_rd_idx = araddr[`ACL_AXI_ADDR_W-1:2];
  assign rd_mapped = (reg_rd_idx <= `ACL_LAST_IDX);

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      rvalid_ff <= 1'b0;
      rresp_ff <= `ACL_RESP_OKAY;
      rdata_ff <= 32'h0;
    end
    else if (arvalid && arready)
    begin
      rvalid_ff <= 1'b1;
      rresp_ff <= rd_mapped ? `ACL_RESP_OKAY : `ACL_RESP_SLVERR;
      rdata_ff <= {24'h0, rd_mapped ? reg_rd_data : 8'h00};
    end
    else if (rready)
    begin
      rvalid_ff <= 1'b0;
    end
  end

  assign rvalid = rvalid_ff;
  assign rresp = rresp_ff;
  assign rdata = rdata_ff;

endmodule
